// File: core/drsf_top.sv
/*
 Result handling of a code reader fieldbus front end: per-gate code counting,
 unfetched result counter, interlinking, fragmenting and the status byte.
 Assumes decoder events are one-cycle pulses synchronous to clk and that the
 controller raises frag_ack for one cycle per fetched fragment.
*/
`timescale 1ns/10ps
// Operation
// - Minimum codes per gate setting, 0 to 64, default 0
// - Maximum codes setting, default 1; gate ends early at that count
// - Minimum of zero is ignored entirely
// - Count within limits suppresses extra failed-read results
// - Report unfetched results as 8-bit count
// - Fragment length setting 1 to 28, default 1
// - Byte 0: fragment number low nibble, remaining fragments high nibble
// - Byte 1 fragment size equals configured length except last
// - Fragments advance one at a time under handshake
// - Interlinked mode merges all gate results into one
// - Separator inserted between merged results unless zero
// - Status bit 0 shows gate state
// - Bit 1 new result, bit 2 failed read
// - Bit 3 more buffered results, bit 4 buffers full
// - Bits 5 and 6 toggle on new result and failed read
// - Bit 7 set while waiting for acknowledgement
// - Gate, more, overflow, wait bits update immediately
// - Other flags describe the result being output
// - Init-value reset clears new-result and result-state bits
// - Data reset clears status except gate, overflow, wait and toggle bits
// - Data reset aborts fragment transfer
// - Decoding-dependent mode ends gate at configured count
module drsf_top
    import drsf_pkg::*;
#(
    parameter int LEN_W = 8 // Result length width
) (
    input wire logic clk, // 125 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic [7:0] min_codes, // Minimum codes per gate
    input wire logic [7:0] max_codes, // Maximum codes per gate
    input wire logic [7:0] gate_end_mode, // Completeness mode
    input wire logic [7:0] frag_len_cfg, // Fragment length
    input wire logic interlink_en, // Interlinked mode
    input wire logic [7:0] separator, // Separator character
    input wire logic gate_on, // Reading gate level
    input wire logic code_ok, // Pulse: distinct code decoded
    input wire logic [LEN_W-1:0] code_len, // Length with code_ok
    input wire logic gate_close, // Pulse: gate ended
    input wire logic buf_full, // Result buffers full
    input wire logic ack_wait, // Control awaiting ack
    input wire logic result_fetch, // Pulse: controller fetched result
    input wire logic frag_ack, // Pulse: fragment handshake
    input wire logic init_clear, // Pulse: input data to init value
    input wire logic data_reset, // Pulse: data reset
    output logic gate_end_req, // Pulse: end gate early
    output logic read_failed_indication, // Pulse: emit failed read
    output logic [7:0] pending_count, // Unfetched results
    output logic [7:0] status, // Decoder status byte
    output logic [7:0] frag_info, // Fragment number and remaining
    output logic [7:0] frag_size, // Current fragment size
    output logic [7:0] frag_offset, // Byte offset of fragment
    output logic [7:0] merged_len, // Output result length, merged when interlinked
    output logic frag_busy // Fragment transfer active
);
    logic rst_q1, rst_n_s;
    logic [7:0] gate_cnt, next_gate_cnt;
    logic [7:0] pend, next_pend;
    logic [7:0] mlen, next_mlen;
    logic mhas, next_mhas;
    logic new_res, next_new_res;
    logic fail_res, next_fail_res;
    logic tog_new, next_tog_new;
    logic tog_fail, next_tog_fail;
    logic end_req, next_end_req;
    logic nr_req, next_nr_req;
    drsf_state_t st, next_st;
    logic [7:0] min_eff, max_eff, flen_eff;
    logic in_range, emit, fail_emit, hit_max;
    logic [7:0] emit_len;
    drsf_frag_if fi ();

    // Two-stage reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q1 <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n_s <= rst_q1;
        end
    end

    // Clamp settings to their documented ranges
    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Saturating add of one byte to another
    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? 8'hFF : s[7:0];
    endfunction

    // Setting decode and gate-end evaluation
    always_comb begin
        min_eff = clamp(min_codes, 8'h00, DRSF_CODES_LIMIT);
        max_eff = clamp(max_codes, 8'h00, DRSF_CODES_LIMIT);
        flen_eff = clamp(frag_len_cfg, DRSF_FRAG_LEN_MIN, DRSF_FRAG_LEN_MAX);
        // Zero minimum drops the lower bound entirely
        in_range = ((min_eff == 8'h00) || (gate_cnt >= min_eff))
                   && (gate_cnt <= max_eff || max_eff == 8'h00);
        hit_max = code_ok && (max_eff != 8'h00)
                  && (gate_cnt + 8'h01 == max_eff);
        // A closing gate with nothing decoded, or below the minimum or above a nonzero maximum, fails
        fail_emit = gate_close && (gate_cnt == 8'h00 || !in_range);
        emit = interlink_en ? (gate_close && mhas) : code_ok;
        emit_len = interlink_en ? mlen : 8'(code_len);
    end

    // Gate counters, merge length and pending results
    always_comb begin
        next_gate_cnt = gate_cnt;
        next_mlen = mlen;
        next_mhas = mhas;
        next_pend = pend;
        next_end_req = 1'b0;
        next_nr_req = 1'b0;
        if (code_ok) begin
            next_gate_cnt = sat_add(gate_cnt, 8'h01);
            // Separator only between results, never before the first
            if (mhas && separator != DRSF_SEP_NONE) begin
                next_mlen = sat_add(sat_add(mlen, 8'h01), 8'(code_len));
            end else begin
                next_mlen = sat_add(mlen, 8'(code_len));
            end
            next_mhas = 1'b1;
            next_end_req = hit_max && (gate_end_mode == DRSF_MODE_DECODE);
        end
        if (gate_close) begin
            next_gate_cnt = 8'h00;
            next_mlen = 8'h00;
            next_mhas = 1'b0;
            next_nr_req = fail_emit;
        end
        // Counter saturates; a set and a fetch in the same cycle leave it unchanged
        if ((emit || fail_emit) && !result_fetch) begin
            next_pend = sat_add(pend, 8'h01);
        end else if (result_fetch && !(emit || fail_emit) && pend != 8'h00) begin
            next_pend = pend - 8'h01;
        end
        if (data_reset) begin
            next_pend = 8'h00;
            next_mlen = 8'h00;
            next_mhas = 1'b0;
            next_gate_cnt = 8'h00;
        end
    end

    // Level and toggle bits describing the output result
    always_comb begin
        next_new_res = new_res;
        next_fail_res = fail_res;
        next_tog_new = tog_new;
        next_tog_fail = tog_fail;
        if (init_clear || data_reset) begin
            next_new_res = 1'b0;
            next_fail_res = 1'b0;
        end
        // New output result overrides a clear in the same cycle
        if (emit) begin
            next_new_res = 1'b1;
            next_fail_res = 1'b0;
            next_tog_new = ~tog_new;
        end else if (fail_emit) begin
            next_new_res = 1'b1;
            next_fail_res = 1'b1;
            next_tog_new = ~tog_new;
            next_tog_fail = ~tog_fail;
        end
    end

    // Fragment session control
    always_comb begin
        next_st = st;
        case (st)
            DRSF_IDLE: begin
                if (emit && !data_reset) begin
                    next_st = DRSF_SEND;
                end
            end
            DRSF_SEND: begin
                next_st = DRSF_WAIT;
            end
            DRSF_WAIT: begin
                if (!fi.busy) begin
                    next_st = DRSF_IDLE;
                end
            end
            default: begin
                next_st = DRSF_IDLE;
            end
        endcase
        if (data_reset) begin
            next_st = DRSF_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            gate_cnt <= 8'h00;
            mlen <= 8'h00;
            mhas <= 1'b0;
            pend <= 8'h00;
            new_res <= 1'b0;
            fail_res <= 1'b0;
            tog_new <= 1'b0;
            tog_fail <= 1'b0;
            end_req <= 1'b0;
            nr_req <= 1'b0;
            merged_len <= 8'h00;
            st <= DRSF_IDLE;
        end else if (ce) begin
            gate_cnt <= next_gate_cnt;
            mlen <= next_mlen;
            mhas <= next_mhas;
            pend <= next_pend;
            new_res <= next_new_res;
            fail_res <= next_fail_res;
            tog_new <= next_tog_new;
            tog_fail <= next_tog_fail;
            end_req <= next_end_req;
            nr_req <= next_nr_req;
            merged_len <= (emit && !data_reset) ? emit_len : (data_reset ? 8'h00 : merged_len);
            st <= next_st;
        end
    end

    // Fragment channel hookup
    assign fi.start = (st == DRSF_SEND);
    assign fi.abort = data_reset;
    assign fi.total_len = merged_len;
    assign fi.frag_len = flen_eff;
    assign fi.ack = frag_ack;

    drsf_frag_seq u_seq (
        .clk(clk),
        .rst_n(rst_n_s),
        .ce(ce),
        .fi(fi)
    );

    // Live bits come straight from their sources
    always_comb begin
        status = DRSF_STATUS_RST;
        status[DRSF_ST_GATE] = gate_on;
        status[DRSF_ST_NEW] = new_res;
        status[DRSF_ST_FAIL] = fail_res;
        status[DRSF_ST_MORE] = (pend > 8'h01);
        status[DRSF_ST_OVFL] = buf_full;
        status[DRSF_ST_TNEW] = tog_new;
        status[DRSF_ST_TFAIL] = tog_fail;
        status[DRSF_ST_WACK] = ack_wait;
    end

    assign pending_count = pend;
    assign gate_end_req = end_req;
    assign read_failed_indication = nr_req;
    assign frag_info = fi.frag_info;
    assign frag_size = fi.frag_size;
    assign frag_offset = fi.frag_offset;
    assign frag_busy = fi.busy;

    property p_tog_new;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && emit) |=> (tog_new != $past(tog_new)) && new_res;
    endproperty
    a_tog_new: assert property (p_tog_new) else $error("New toggle missed");

    property p_fail_flag;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && fail_emit && !emit) |=> fail_res && (tog_fail != $past(tog_fail));
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("Failed read flag wrong");

    property p_dreset_keep;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && data_reset && !emit && !fail_emit)
            |=> !new_res && !fail_res && pend == 8'h00 && $stable(tog_new) && $stable(tog_fail);
    endproperty
    a_dreset_keep: assert property (p_dreset_keep) else $error("Data reset wrong");

    property p_init_clear;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && init_clear && !emit && !fail_emit) |=> !new_res && !fail_res && $stable(tog_new);
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("Init clear wrong");

    property p_end_req;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && hit_max && gate_end_mode == DRSF_MODE_DECODE) |=> gate_end_req;
    endproperty
    a_end_req: assert property (p_end_req) else $error("Gate end missed");

    property p_pend_up;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && emit && !result_fetch && !data_reset && pend < 8'hFF)
            |=> pend == $past(pend) + 8'h01;
    endproperty
    a_pend_up: assert property (p_pend_up) else $error("Pending count wrong");

    property p_live_bits;
        @(posedge clk) disable iff (!rst_n_s)
        status[DRSF_ST_OVFL] == buf_full && status[DRSF_ST_WACK] == ack_wait
            && status[DRSF_ST_GATE] == gate_on;
    endproperty
    a_live_bits: assert property (p_live_bits) else $error("Live status bits lag");

    property p_abort;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && data_reset) |=> !frag_busy && frag_info == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("Fragment not aborted");

    // A gate that ends inside its limits must not add a failed read
    property p_in_range_ok;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && gate_close && gate_cnt != 8'h00 && in_range) |=> !read_failed_indication;
    endproperty
    a_in_range_ok: assert property (p_in_range_ok) else $error("Extra failed read");

    property p_pend_down;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && result_fetch && !emit && !fail_emit && !data_reset && pend != 8'h00)
            |=> pend == $past(pend) - 8'h01;
    endproperty
    a_pend_down: assert property (p_pend_down) else $error("Fetch not counted");

    property p_frag_start;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && st == DRSF_SEND && !data_reset) |=> frag_busy && frag_info[3:0] == 4'h0;
    endproperty
    a_frag_start: assert property (p_frag_start) else $error("Start wrong");
endmodule // drsf_top

// File: core/drsf_pkg.sv
/*
 Package for the decode result, status and fragmenter block: parameter
 defaults, status bit positions, fragment field layout and state codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package drsf_pkg;
    // Multi-label settings
    localparam logic [7:0] DRSF_MIN_CODES_RST = 8'h00;
    localparam logic [7:0] DRSF_MAX_CODES_RST = 8'h01;
    localparam logic [7:0] DRSF_CODES_LIMIT = 8'h40;
    // Fragment settings
    localparam logic [7:0] DRSF_FRAG_LEN_RST = 8'h01;
    localparam logic [7:0] DRSF_FRAG_LEN_MAX = 8'h1C;
    localparam logic [7:0] DRSF_FRAG_LEN_MIN = 8'h01;
    localparam int DRSF_FRAG_NUM_LSB = 0;
    localparam int DRSF_FRAG_REM_LSB = 4;
    // Interlink separator, zero means none
    localparam logic [7:0] DRSF_SEP_NONE = 8'h00;
    // Status byte bit positions
    localparam int DRSF_ST_GATE = 0;
    localparam int DRSF_ST_NEW = 1;
    localparam int DRSF_ST_FAIL = 2;
    localparam int DRSF_ST_MORE = 3;
    localparam int DRSF_ST_OVFL = 4;
    localparam int DRSF_ST_TNEW = 5;
    localparam int DRSF_ST_TFAIL = 6;
    localparam int DRSF_ST_WACK = 7;
    localparam logic [7:0] DRSF_STATUS_RST = 8'h00;
    localparam logic [7:0] DRSF_PENDING_MAX = 8'hFF;
    // Completeness mode dependent on decoding
    localparam logic [7:0] DRSF_MODE_DECODE = 8'h01;

    typedef enum logic [1:0] {
        DRSF_IDLE = 2'b00,
        DRSF_SEND = 2'b01,
        DRSF_WAIT = 2'b10
    } drsf_state_t;
endpackage

// File: core/drsf_frag_if.sv
/*
 Interface carrying fragment setup and handshake between the top and the
 fragment sequencer. Assumes both ends share clk.
*/
`timescale 1ns/10ps
interface drsf_frag_if;
    logic start;
    logic abort;
    logic [7:0] total_len;
    logic [7:0] frag_len;
    logic ack;
    logic busy;
    logic [7:0] frag_info;
    logic [7:0] frag_size;
    logic [7:0] frag_offset;
    modport top (output start, abort, total_len, frag_len, ack,
                 input busy, frag_info, frag_size, frag_offset);
    modport seq (input start, abort, total_len, frag_len, ack,
                 output busy, frag_info, frag_size, frag_offset);
endinterface

// File: core/drsf_frag_seq.sv
/*
 Fragment sequencer: splits one result length into numbered fragments that
 advance on handshake. Assumes reset is already synchronised by the top.
*/
`timescale 1ns/10ps
module drsf_frag_seq
    import drsf_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset
    input wire logic ce, // Clock enable
    drsf_frag_if.seq fi // Fragment channel
);
    logic [3:0] num, next_num;
    logic [3:0] rem, next_rem;
    logic [7:0] size, next_size;
    logic [7:0] left, next_left;
    logic [7:0] off, next_off;
    logic busy, next_busy;

    function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
        min8 = (a < b) ? a : b;
    endfunction

    // Fragments left after the first for a length, counting at least one fragment, at most 15
    function automatic logic [3:0] nfrag(input logic [7:0] len, input logic [7:0] fl);
        logic [8:0] q;
        q = 9'h000;
        if (fl != 8'h00) begin
            q = 9'((len + fl - 9'h001) / fl);
        end
        if (q == 9'h000) begin
            q = 9'h001;
        end
        nfrag = (q > 9'h010) ? 4'hF : 4'(q - 9'h001);
    endfunction

    // Next fragment state; fields move together, except the ack on the last fragment, which only clears busy
    always_comb begin
        next_num = num;
        next_rem = rem;
        next_size = size;
        next_left = left;
        next_off = off;
        next_busy = busy;
        if (fi.abort) begin
            next_num = 4'h0;
            next_rem = 4'h0;
            next_size = 8'h00;
            next_left = 8'h00;
            next_off = 8'h00;
            next_busy = 1'b0;
        end else if (fi.start && !busy) begin
            next_num = 4'h0;
            next_rem = nfrag(fi.total_len, fi.frag_len);
            next_size = min8(fi.total_len, fi.frag_len);
            next_left = fi.total_len - min8(fi.total_len, fi.frag_len);
            next_off = 8'h00;
            next_busy = 1'b1;
        end else if (fi.ack && busy) begin
            if (rem == 4'h0) begin
                next_busy = 1'b0;
            end else begin
                next_num = num + 4'h1;
                next_rem = rem - 4'h1;
                next_off = off + size;
                next_size = min8(left, fi.frag_len);
                next_left = left - min8(left, fi.frag_len);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            num <= 4'h0;
            rem <= 4'h0;
            size <= 8'h00;
            left <= 8'h00;
            off <= 8'h00;
            busy <= 1'b0;
        end else if (ce) begin
            num <= next_num;
            rem <= next_rem;
            size <= next_size;
            left <= next_left;
            off <= next_off;
            busy <= next_busy;
        end
    end

    assign fi.frag_info = {rem, num};
    assign fi.frag_size = size;
    assign fi.frag_offset = off;
    assign fi.busy = busy;

    property p_frag_step;
        @(posedge clk) disable iff (!rst_n)
        (ce && busy && fi.ack && !fi.abort && rem != 4'h0)
            |=> (num == $past(num) + 4'h1) && (rem == $past(rem) - 4'h1);
    endproperty
    a_frag_step: assert property (p_frag_step) else $error("Fragment step wrong");

    property p_frag_hold;
        @(posedge clk) disable iff (!rst_n)
        (ce && busy && !fi.ack && !fi.abort) |=> $stable(fi.frag_info) && $stable(size);
    endproperty
    a_frag_hold: assert property (p_frag_hold) else $error("Fragment moved without ack");
endmodule // drsf_frag_seq

// File: sim/drsf_ctrl_model.sv
/*
 Controller model: acks each newly shown fragment after a set delay.
 Assumes fragments show on frag_info while frag_busy is high.
*/
`timescale 1ns/10ps
module drsf_ctrl_model (
    input wire logic clk, // System clock
    input wire logic [7:0] frag_info, // Shown fragment fields
    input wire logic frag_busy, // Transfer active
    input wire logic [3:0] delay, // Extra cycles before ack
    output logic frag_ack // Handshake pulse
);
    logic [7:0] seen;
    logic was_busy;
    // One ack per fragment; looks at settled values only, between edges
    initial begin
        frag_ack = 1'b0;
        was_busy = 1'b0;
        seen = 8'h00;
        forever begin
            @(negedge clk);
            if (frag_busy === 1'b1 && (!was_busy || frag_info !== seen)) begin
                seen = frag_info;
                was_busy = 1'b1;
                repeat (delay) @(posedge clk);
                @(posedge clk);
                #1 frag_ack = 1'b1;
                @(posedge clk);
                #1 frag_ack = 1'b0;
            end else begin
                was_busy = frag_busy;
            end
        end
    end
endmodule // drsf_ctrl_model

// File: sim/test_drsf_top.sv
/*
 Self-checking bench for the result, status and fragmenter top.
 Assumes the controller model acks fragments; ce is held high.
*/
`timescale 1ns/10ps
module test_drsf_top;
    import drsf_pkg::*;
    logic clk, reset_n, interlink_en, gate_on, code_ok, gate_close, buf_full, ack_wait;
    logic result_fetch, frag_ack, init_clear, data_reset, gate_end_req, rfi, frag_busy;
    logic watch, mon_busy, tnew, tfail;
    logic [7:0] min_codes, max_codes, gate_end_mode, frag_len_cfg, separator, code_len;
    logic [7:0] pending_count, status, frag_info, frag_size, frag_offset, merged_len, last;
    logic [3:0] delay;
    logic [23:0] note;
    logic [23:0] notes[$];
    int num_errors, checked, f, len, total;
    logic [7:0] tab [0:5][0:3] = '{'{8'h00, 8'h00, 8'h00, 8'h01}, '{8'h00, 8'h00, 8'h01, 8'h00},
        '{8'h03, 8'h05, 8'h04, 8'h00}, '{8'h03, 8'h05, 8'h02, 8'h01},
        '{8'h00, 8'h02, 8'h03, 8'h01}, '{8'h40, 8'h40, 8'h02, 8'h01}};

    drsf_top u_dut (.clk(clk), .reset_n(reset_n), .ce(1'b1), .min_codes(min_codes),
        .max_codes(max_codes), .gate_end_mode(gate_end_mode), .frag_len_cfg(frag_len_cfg),
        .interlink_en(interlink_en), .separator(separator), .gate_on(gate_on),
        .code_ok(code_ok), .code_len(code_len), .gate_close(gate_close), .buf_full(buf_full),
        .ack_wait(ack_wait), .result_fetch(result_fetch), .frag_ack(frag_ack),
        .init_clear(init_clear), .data_reset(data_reset), .gate_end_req(gate_end_req),
        .read_failed_indication(rfi), .pending_count(pending_count), .status(status),
        .frag_info(frag_info), .frag_size(frag_size), .frag_offset(frag_offset),
        .merged_len(merged_len), .frag_busy(frag_busy));
    drsf_ctrl_model u_ctrl (.clk(clk), .frag_info(frag_info), .frag_busy(frag_busy),
        .delay(delay), .frag_ack(frag_ack));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // code_ok stays high until the next task, so it is never written twice in a step
    task automatic code(input logic [7:0] l, input logic end_exp);
        code_ok = 1'b1;
        code_len = l;
        tick();
        if (!interlink_en) tnew = ~tnew;
        chk({7'h00, gate_end_req}, {7'h00, end_exp}, "gate end");
    endtask

    task automatic shut(input logic fail);
        code_ok = 1'b0;
        gate_close = 1'b1;
        tick();
        gate_close = 1'b0;
        if (fail) tfail = ~tfail;
        chk({7'h00, rfi}, {7'h00, fail}, "failed read");
    endtask

    task automatic fetch();
        code_ok = 1'b0;
        result_fetch = 1'b1;
        tick();
        result_fetch = 1'b0;
    endtask

    // Expected fragment sequence: fields, offset, size
    task automatic frags(input int l, input int fl);
        int n;
        n = (l == 0) ? 1 : (l + fl - 1) / fl;
        for (int k = 0; k < n; k++) begin
            notes.push_back({4'(n - 1 - k), 4'(k), 8'(k * fl),
                             8'((k < n - 1) ? fl : l - (n - 1) * fl)});
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) tick();
        while ((frag_busy !== 1'b0 || notes.size() != 0) && n < 600) begin
            tick();
            n++;
        end
        if (n >= 600) begin
            num_errors++;
            $display("wrong value at %0t: transfer hung", $time);
        end
    endtask

    task automatic dreset(input logic [7:0] mask);
        data_reset = 1'b1;
        tick();
        data_reset = 1'b0;
        chk(pending_count, 8'h00, "pending");
        chk(status & mask, {1'b0, tfail, tnew, 4'h0, gate_on} & mask, "status kept");
        chk({7'h00, frag_busy}, 8'h00, "abort");
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Takes the oldest note whenever a new fragment shows
    always @(negedge clk) begin
        if (frag_busy === 1'b1 && (frag_info !== last || !mon_busy) && watch) begin
            if (notes.size() == 0) begin
                num_errors++;
                $display("wrong value at %0t: unexpected fragment", $time);
            end else begin
                note = notes.pop_front();
                chk(frag_info, note[23:16], "fragment fields");
                chk(frag_offset, note[15:8], "fragment offset");
                chk(frag_size, note[7:0], "fragment size");
            end
        end
        last = frag_info;
        mon_busy = frag_busy;
    end

    // Hang guard
    initial begin
        #(8 * 30000);
        num_errors++;
        close_out();
    end

    initial begin
        void'($urandom(32'hC0C3));
        {interlink_en, gate_on, code_ok, gate_close, buf_full, ack_wait} = 6'h00;
        {result_fetch, init_clear, data_reset, watch, tnew, tfail, mon_busy} = 7'h00;
        {min_codes, max_codes} = {DRSF_MIN_CODES_RST, DRSF_MAX_CODES_RST};
        gate_end_mode = DRSF_MODE_DECODE;
        {frag_len_cfg, separator, code_len, last, delay} = {DRSF_FRAG_LEN_RST, 24'h000000, 4'h0};
        {num_errors, checked, reset_n} = 0;
        repeat (6) @(posedge clk);
        #1;
        chk(status, DRSF_STATUS_RST, "status in reset");
        chk(pending_count, 8'h00, "pending in reset");
        reset_n = 1'b1;
        repeat (3) tick();
        for (int i = 0; i < 9; i++) begin
            {gate_on, buf_full, ack_wait} = 3'(i);
            tick();
            chk(status & 8'h01, {7'h00, gate_on}, "gate");
            chk(status & 8'h90, {ack_wait, 2'h0, buf_full, 4'h0}, "live");
        end
        watch = 1'b1;
        for (int i = 0; i < 6; i++) begin
            f = (i == 0) ? 1 : (i == 1) ? 28 : 1 + $urandom % 28;
            len = (i == 2) ? 0 : $urandom % 256;
            if (len > 16 * f) len = 16 * f;
            frag_len_cfg = 8'(f);
            delay = 4'($urandom % 4);
            frags(len, f);
            code(8'(len), 1'b1);
            chk(status & 8'h26, {2'b00, tnew, 5'h02}, "new flags");
            chk(pending_count, 8'h01, "pending");
            shut(1'b0);
            wait_idle();
            fetch();
            chk(pending_count, 8'h00, "fetched");
        end
        watch = 1'b0;
        {max_codes, gate_end_mode} = 16'h0000;
        for (int i = 1; i <= 3; i++) begin
            code(8'h04, 1'b0);
            chk(pending_count, 8'(i), "pending");
        end
        chk(status & 8'h08, 8'h08, "more results");
        fetch();
        chk(pending_count, 8'h02, "fetched");
        dreset(8'h67);
        shut(1'b1);
        for (int i = 0; i < 6; i++) begin
            {min_codes, max_codes} = {tab[i][0], tab[i][1]};
            for (int k = 0; k < tab[i][2]; k++) code(8'h02, 1'b0);
            shut(tab[i][3][0]);
            chk(status & 8'h44, {1'b0, tfail, 3'h0, tab[i][3][0], 2'h0}, "read");
        end
        init_clear = 1'b1;
        tick();
        init_clear = 1'b0;
        chk(status & 8'h47, {1'b0, tfail, 5'h00, gate_on}, "init clear");
        wait_idle();
        dreset(8'h47);
        {watch, interlink_en, min_codes, max_codes} = {2'b11, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            separator = (i == 0) ? DRSF_SEP_NONE : 8'(1 + $urandom % 255);
            f = 3 + $urandom % 26;
            {frag_len_cfg, delay} = {8'(f), 4'(i * 2)};
            total = (i == 0) ? 0 : 2;
            for (int k = 0; k < 3; k++) begin
                len = 1 + $urandom % 8;
                total += len;
                code(8'(len), 1'b0);
            end
            frags(total, f);
            shut(1'b0);
            chk(merged_len, 8'(total), "merged length");
            wait_idle();
        end
        close_out();
    end
endmodule // test_drsf_top
